//--- hdl/crs_core_regs.sv
// Contract
// - Registers reached only by operations; code also maps them for direct command port reads
// - Accumulator 8-bit ALU operand, reset-free
// - Index pointer is upper:lower byte
// - Lower index byte usable as data
// - Reset clears upper index byte only
// - Stack pointer marks next free slot
// - Stack add uses sign-extended immediate
// - Stack pointer resets to 0x00ff
// - Stack reset touches low byte only
// - Counter increments on fetch, else loads
// - Reset loads counter from top vector
// - Flag bits 6 and 5 read one
// - Bit 7 flags signed overflow
// - Bit 4 carries bit 3 to 4
// - Decimal adjust uses half and carry
// - Bit 3 set blocks interrupts
// - Entry sets mask after stacking
// - No interrupt right after mask clear
// - Bit 2 is result sign
// - Bit 1 flags zero result
// - Bit 0 carry, borrow, shift out
`timescale 1ns/1ns
`include "crs_defines.svh"

module crs_core_regs (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_req,
  output logic      [15:0] mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  output logic      [15:0] ix_pointer,
  output logic      [15:0] stack_pointer,
  output logic      [15:0] program_counter,
  output logic             irq_accept
);
  import crs_pkg::*;

  // ********************************
  // Reset release and pin sync
  // ********************************
  logic rst_meta_q;
  logic rstn_q;
  logic irq_meta_q;
  logic irq_sync_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rstn_q     <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q     <= rst_meta_q;
    end
  end

  always_ff @(posedge clk or negedge rstn_q) begin
    if (!rstn_q) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_req;
      irq_sync_q <= irq_meta_q;
    end
  end

  // ********************************
  // State
  // ********************************
  crs_state_t  state_q;
  logic [7:0]  acc_q;
  logic [7:0]  x_q;
  logic [7:0]  h_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0]  flags_q;
  logic [15:0] opnd_q;
  logic [7:0]  vec_hi_q;
  logic        block_q;
  logic        irq_accept_q;
  logic [15:0] mem_addr_q;
  logic        mem_rd_q;

  // ********************************
  // Command port decode
  // ********************************
  wire logic        apb_acc;
  wire logic        apb_wr;
  wire logic        hit_cmd;
  wire logic        mapped;
  wire logic        run;
  wire logic        exec;
  wire crs_op_t     op;
  wire logic [7:0]  imm;
  wire logic [15:0] hx;
  wire logic [15:0] imm_sext;
  wire logic [15:0] hx_inc;

  assign apb_acc  = psel & penable;
  assign apb_wr   = apb_acc & pwrite;
  assign hit_cmd  = (paddr == `CRS_OFF_CMD);
  assign mapped   = hit_cmd | (paddr == `CRS_OFF_OPND) | (paddr == `CRS_OFF_ACC) |
                    (paddr == `CRS_OFF_IDX) | (paddr == `CRS_OFF_SP) |
                    (paddr == `CRS_OFF_PC) | (paddr == `CRS_OFF_FLAGS) |
                    (paddr == `CRS_OFF_STAT);
  assign run      = (state_q == ST_RUN);
  assign exec     = apb_wr & hit_cmd & run;
  assign op       = crs_op_t'(pwdata[4:0]);
  assign imm      = opnd_q[7:0];
  assign hx       = {h_q, x_q};
  assign imm_sext = {{8{imm[7]}}, imm};
  assign hx_inc   = hx + 16'h0001;

  assign pready  = 1'b1;
  assign pslverr = apb_acc & (!mapped | (pwrite & hit_cmd & !run));

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `CRS_OFF_OPND:  prdata = {16'h0000, opnd_q};
      `CRS_OFF_ACC:   prdata = {24'h00_0000, acc_q};
      `CRS_OFF_IDX:   prdata = {16'h0000, hx};
      `CRS_OFF_SP:    prdata = {16'h0000, sp_q};
      `CRS_OFF_PC:    prdata = {16'h0000, pc_q};
      `CRS_OFF_FLAGS: prdata = {24'h00_0000, flags_q};
      `CRS_OFF_STAT:  prdata = {28'h000_0000, state_q, block_q, irq_accept_q};
      default:        prdata = 32'h0000_0000;
    endcase
  end

  // ********************************
  // Datapath units
  // ********************************
  wire logic [7:0]  alu_res;
  wire logic        alu_wr_a;
  wire logic        alu_wr_x;
  wire logic [7:0]  alu_flags;
  wire logic [15:0] sp_next;

  crs_alu u_alu (
    .op      (op),
    .acc     (acc_q),
    .xr      (x_q),
    .imm     (imm),
    .flags   (flags_q),
    .res     (alu_res),
    .wr_a    (alu_wr_a),
    .wr_x    (alu_wr_x),
    .flags_d (alu_flags)
  );

  crs_spu u_spu (
    .op   (op),
    .sp_q (sp_q),
    .imm  (imm),
    .sp_d (sp_next)
  );

  // ********************************
  // Flag next value
  // ********************************
  logic [7:0] flags_d;

  always_comb begin
    flags_d = alu_flags;
    if (op == OP_LDHX || op == OP_STHX) begin
      flags_d[`CRS_FLG_N] = (op == OP_LDHX) ? opnd_q[15] : hx[15];
      flags_d[`CRS_FLG_Z] = (op == OP_LDHX) ? (opnd_q == 16'h0000) : (hx == 16'h0000);
      flags_d[`CRS_FLG_V] = 1'b0;
    end
    flags_d = flags_d | `CRS_FLG_ONES;
  end

  // ********************************
  // Data registers, no reset
  // ********************************
  // Reset leaves accumulator
  always_ff @(posedge clk) begin
    if (exec && alu_wr_a) begin
      acc_q <= alu_res;
    end
  end

  always_ff @(posedge clk) begin
    if (exec && op == OP_LDHX) begin
      x_q <= opnd_q[7:0];
    end else if (exec && op == OP_IXINC) begin
      x_q <= x_q + 8'h01;
    end else if (exec && alu_wr_x) begin
      x_q <= alu_res;
    end
  end

  // ********************************
  // Control registers
  // ********************************
  always_ff @(posedge clk or negedge rstn_q) begin
    if (!rstn_q) begin
      h_q <= `CRS_H_RST;
      sp_q    <= `CRS_SP_RST;
      flags_q <= `CRS_FLAGS_RST;
      opnd_q  <= 16'h0000;
    end else begin
      if (apb_wr && paddr == `CRS_OFF_OPND) begin
        opnd_q <= pwdata[15:0];
      end
      if (exec && op == OP_LDHX) begin
        h_q <= opnd_q[15:8];
      end else if (exec && op == OP_IXINC) begin
        h_q <= hx_inc[15:8];
      end
      if (exec) begin
        sp_q    <= sp_next;
        flags_q <= flags_d;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn_q) begin
    if (!rstn_q) begin
      state_q    <= ST_VREQ;
      mem_addr_q <= `CRS_VEC_HI_ADR;
      mem_rd_q   <= 1'b1;
      vec_hi_q   <= 8'h00;
      pc_q       <= 16'h0000;
    end else begin
      case (state_q)
        ST_VREQ: begin
          mem_addr_q <= `CRS_VEC_LO_ADR;
          state_q    <= ST_VHI;
        end
        ST_VHI: begin
          vec_hi_q <= mem_rdata;
          mem_rd_q <= 1'b0;
          state_q  <= ST_VLO;
        end
        ST_VLO: begin
          pc_q    <= {vec_hi_q, mem_rdata};
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (exec && op == OP_FETCH) begin
            pc_q <= pc_q + 16'h0001;
          end else if (exec && (op == OP_JMP || op == OP_INTR)) begin
            pc_q <= opnd_q;
          end else if (exec && op == OP_BRA) begin
            pc_q <= pc_q + imm_sext;
          end
        end
        default: state_q <= ST_VREQ;
      endcase
    end
  end

  // ********************************
  // Interrupt gate
  // ********************************
  wire logic mask_cleared;
  wire logic irq_ok;

  assign mask_cleared = exec & flags_q[`CRS_FLG_I] & !flags_d[`CRS_FLG_I];
  assign irq_ok = irq_sync_q & run & !flags_q[`CRS_FLG_I] & !block_q;

  always_ff @(posedge clk or negedge rstn_q) begin
    if (!rstn_q) begin
      block_q      <= 1'b0;
      irq_accept_q <= 1'b0;
    end else begin
      if (mask_cleared) begin
        block_q <= 1'b1;
      end else if (exec) begin
        block_q <= 1'b0;
      end
      irq_accept_q <= irq_ok;
    end
  end

  assign mem_addr        = mem_addr_q;
  assign mem_rd          = mem_rd_q;
  assign ix_pointer      = hx;
  assign stack_pointer   = sp_q;
  assign program_counter = pc_q;
  assign irq_accept      = irq_accept_q;

  // ********************************
  // Checks
  // ********************************
  a_reset_values: assert property (@(posedge clk)
    $rose(rstn_q) |-> (h_q == 8'h00) && (sp_q == 16'h00ff))
    else $error("Upper index or stack pointer wrong after reset");

  a_fixed_ones: assert property (@(posedge clk) disable iff (!rstn_q)
    flags_q[6:5] == 2'b11)
    else $error("Fixed flag bits not one");

  a_stack_add: assert property (@(posedge clk) disable iff (!rstn_q)
    exec && op == OP_AIS |=> sp_q == $past(sp_q) + {{8{$past(opnd_q[7])}}, $past(opnd_q[7:0])})
    else $error("Stack add not sign extended");

  a_stack_reset: assert property (@(posedge clk) disable iff (!rstn_q)
    exec && op == OP_RSP |=> (sp_q[15:8] == $past(sp_q[15:8])) && (sp_q[7:0] == 8'hff))
    else $error("Stack reset changed high byte");

  a_mask_blocks: assert property (@(posedge clk) disable iff (!rstn_q)
    flags_q[3] |=> !irq_accept_q)
    else $error("Interrupt accepted while masked");

  a_clear_shadow: assert property (@(posedge clk) disable iff (!rstn_q)
    mask_cleared |=> !irq_accept_q [*2])
    else $error("Interrupt accepted right after mask clear");

  a_fetch_step: assert property (@(posedge clk) disable iff (!rstn_q)
    exec && op == OP_FETCH |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("Counter did not step on fetch");

  a_vector_load: assert property (@(posedge clk) disable iff (!rstn_q)
    $rose(rstn_q) ##0 (state_q == ST_VREQ) |-> ##3 (state_q == ST_RUN))
    else $error("Vector sequence length wrong");

  a_half_carry: assert property (@(posedge clk) disable iff (!rstn_q)
    exec && op == OP_ADD |=>
      flags_q[4] == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(opnd_q[3:0])}) >= 5'h10))
    else $error("Half carry wrong after add");

  a_entry_mask: assert property (@(posedge clk) disable iff (!rstn_q)
    exec && op == OP_INTR |=> flags_q[3] && (sp_q == $past(sp_q) - 16'h0005))
    else $error("Entry did not stack and mask");

endmodule

//--- hdl/crs_defines.svh
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

// ********************************
// Command port offsets
// ********************************
`define CRS_OFF_CMD     12'h000
`define CRS_OFF_OPND    12'h004
`define CRS_OFF_ACC     12'h008
`define CRS_OFF_IDX     12'h00c
`define CRS_OFF_SP      12'h010
`define CRS_OFF_PC      12'h014
`define CRS_OFF_FLAGS   12'h018
`define CRS_OFF_STAT    12'h01c

// ********************************
// Reset values and vectors
// ********************************
`define CRS_SP_RST      16'h00ff
`define CRS_H_RST       8'h00
`define CRS_FLAGS_RST   8'h68
`define CRS_VEC_HI_ADR  16'hfffe
`define CRS_VEC_LO_ADR  16'hffff
`define CRS_RSP_LOW     8'hff
`define CRS_IRQ_FRAME   16'h0005

// ********************************
// Flag field positions
// ********************************
`define CRS_FLG_V       7
`define CRS_FLG_H       4
`define CRS_FLG_I       3
`define CRS_FLG_N       2
`define CRS_FLG_Z       1
`define CRS_FLG_C       0
`define CRS_FLG_ONES    8'h60

`endif

//--- hdl/crs_pkg.sv
package crs_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_LDA, OP_STA, OP_LDHX, OP_STHX, OP_ADD, OP_ADC, OP_SUB,
    OP_DAA, OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX, OP_LSRX, OP_ROLX,
    OP_TAX, OP_TXA, OP_TAP, OP_TPA, OP_AIS, OP_RSP, OP_SEI, OP_CLI,
    OP_JMP, OP_BRA, OP_FETCH, OP_INTR, OP_IXINC
  } crs_op_t;

  typedef enum logic [1:0] {
    ST_VREQ, ST_VHI, ST_VLO, ST_RUN
  } crs_state_t;

endpackage

//--- hdl/crs_spu.sv
`timescale 1ns/1ns
`include "crs_defines.svh"

module crs_spu (
  input  crs_pkg::crs_op_t op,
  input  wire logic [15:0] sp_q,
  input  wire logic [7:0]  imm,
  output logic      [15:0] sp_d
);
  import crs_pkg::*;

  wire logic [15:0] imm_sext;
  wire logic [15:0] sp_ais;
  wire logic [15:0] sp_rsp;
  wire logic [15:0] sp_intr;

  assign imm_sext = {{8{imm[7]}}, imm};
  assign sp_ais   = sp_q + imm_sext;
  assign sp_rsp   = {sp_q[15:8], `CRS_RSP_LOW};
  assign sp_intr  = sp_q - `CRS_IRQ_FRAME;

  assign sp_d = (op == OP_AIS)  ? sp_ais :
                (op == OP_RSP)  ? sp_rsp :
                (op == OP_INTR) ? sp_intr : sp_q;

endmodule

//--- hdl/crs_alu.sv
`timescale 1ns/1ns
`include "crs_defines.svh"

module crs_alu (
  input  crs_pkg::crs_op_t op,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  xr,
  input  wire logic [7:0]  imm,
  input  wire logic [7:0]  flags,
  output logic      [7:0]  res,
  output logic             wr_a,
  output logic             wr_x,
  output logic      [7:0]  flags_d
);
  import crs_pkg::*;

  function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] r);
    nz = f;
    nz[`CRS_FLG_N] = r[7];
    nz[`CRS_FLG_Z] = (r == 8'h00);
  endfunction

  wire logic       cin;
  wire logic [8:0] sum9;
  wire logic [4:0] half5;
  wire logic [8:0] dif9;
  wire logic       daa_lo;
  wire logic       daa_hi;
  wire logic [7:0] daa_res;

  assign cin     = (op == OP_ADC) ? flags[`CRS_FLG_C] : 1'b0;
  assign sum9    = {1'b0, acc} + {1'b0, imm} + {8'h00, cin};
  assign half5   = {1'b0, acc[3:0]} + {1'b0, imm[3:0]} + {4'h0, cin};
  assign dif9    = {1'b0, acc} - {1'b0, imm};
  assign daa_lo  = flags[`CRS_FLG_H] | (acc[3:0] > 4'h9);
  assign daa_hi  = flags[`CRS_FLG_C] | (acc > 8'h99);
  assign daa_res = acc + {daa_hi ? 4'h6 : 4'h0, daa_lo ? 4'h6 : 4'h0};

  always_comb begin
    res     = acc;
    wr_a    = 1'b0;
    wr_x    = 1'b0;
    flags_d = flags;
    case (op)
      OP_LDA, OP_STA: begin
        res  = (op == OP_LDA) ? imm : acc;
        wr_a = (op == OP_LDA);
        flags_d = nz(flags, res);
        flags_d[`CRS_FLG_V] = 1'b0;
      end
      OP_ADD, OP_ADC: begin
        res  = sum9[7:0];
        wr_a = 1'b1;
        flags_d = nz(flags, res);
        flags_d[`CRS_FLG_H] = half5[4];
        flags_d[`CRS_FLG_V] = (acc[7] == imm[7]) && (res[7] != acc[7]);
        flags_d[`CRS_FLG_C] = sum9[8];
      end
      OP_SUB: begin
        res  = dif9[7:0];
        wr_a = 1'b1;
        flags_d = nz(flags, res);
        flags_d[`CRS_FLG_V] = (acc[7] != imm[7]) && (res[7] != acc[7]);
        flags_d[`CRS_FLG_C] = dif9[8];
      end
      OP_DAA: begin
        res  = daa_res;
        wr_a = 1'b1;
        flags_d = nz(flags, res);
        flags_d[`CRS_FLG_C] = flags[`CRS_FLG_C] | daa_hi;
      end
      OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX, OP_LSRX, OP_ROLX: begin
        wr_x = 1'b1;
        case (op)
          OP_CLRX: res = 8'h00;
          OP_INCX: res = xr + 8'h01;
          OP_DECX: res = xr - 8'h01;
          OP_COMX: res = ~xr;
          OP_NEGX: res = 8'h00 - xr;
          OP_LSRX: res = {1'b0, xr[7:1]};
          OP_ROLX: res = {xr[6:0], flags[`CRS_FLG_C]};
          default: res = xr;
        endcase
        flags_d = nz(flags, res);
        case (op)
          OP_INCX: flags_d[`CRS_FLG_V] = (xr == 8'h7f);
          OP_DECX: flags_d[`CRS_FLG_V] = (xr == 8'h80);
          OP_NEGX: flags_d[`CRS_FLG_V] = (xr == 8'h80);
          OP_LSRX: flags_d[`CRS_FLG_V] = xr[0];
          OP_ROLX: flags_d[`CRS_FLG_V] = res[7] ^ xr[7];
          default: flags_d[`CRS_FLG_V] = 1'b0;
        endcase
        case (op)
          OP_COMX: flags_d[`CRS_FLG_C] = 1'b1;
          OP_NEGX: flags_d[`CRS_FLG_C] = (res != 8'h00);
          OP_LSRX: flags_d[`CRS_FLG_C] = xr[0];
          OP_ROLX: flags_d[`CRS_FLG_C] = xr[7];
          default: flags_d[`CRS_FLG_C] = flags[`CRS_FLG_C];
        endcase
      end
      OP_TAX: begin
        res  = acc;
        wr_x = 1'b1;
      end
      OP_TXA: begin
        res  = xr;
        wr_a = 1'b1;
      end
      OP_TAP: flags_d = acc;
      OP_TPA: begin
        res  = flags;
        wr_a = 1'b1;
      end
      OP_SEI, OP_INTR: flags_d[`CRS_FLG_I] = 1'b1;
      OP_CLI: flags_d[`CRS_FLG_I] = 1'b0;
      default: res = acc;
    endcase
  end

endmodule

//--- test/crs_core_regs_tb.sv
`timescale 1ns/1ns
`include "crs_defines.svh"

module crs_core_regs_tb;
  import crs_pkg::*;

  logic        clk = 1'b0;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_req;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic [7:0]  mem_rdata = 8'h00;
  logic [15:0] ix_pointer;
  logic [15:0] stack_pointer;
  logic [15:0] program_counter;
  logic        irq_accept;
  logic [31:0] rv;
  logic        ev;
  int          failures;
  int          samples_checked;

  crs_core_regs DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .ix_pointer(ix_pointer), .stack_pointer(stack_pointer), .program_counter(program_counter),
    .irq_accept(irq_accept));

  // ********************************
  // Clock and vector memory
  // ********************************
  always #10 clk = ~clk;

  // Off-vector reads toggle so a stale byte never looks valid
  always @(posedge clk) begin
    mem_rdata <= (mem_addr == `CRS_VEC_HI_ADR) ? 8'h12 : (mem_addr == `CRS_VEC_LO_ADR) ? 8'h34 : ~mem_rdata;
  end

  // ********************************
  // Bus and compare helpers
  // ********************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rv, e, m);
  endtask

  task automatic cmd(input crs_op_t op, input logic [15:0] d);
    apb(1'b1, `CRS_OFF_OPND, {16'h0, d});
    apb(1'b1, `CRS_OFF_CMD, {27'h0, op});
  endtask

  // Polls state; the vector fetch takes a few edges after release
  task automatic wait_run;
    int n;
    n = 0;
    do begin
      apb(1'b0, `CRS_OFF_STAT, 32'h0);
      n++;
    end while (rv[3:2] !== 2'b11 && n < 30);
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    wait_run();
    chk({31'h0, mem_rd}, 32'h0, "vector read done");
    chk({16'h0, mem_addr}, {16'h0, `CRS_VEC_LO_ADR}, "vector low address");
    rdchk(`CRS_OFF_SP, 32'h00ff, "sp reset");
    rdchk(`CRS_OFF_PC, 32'h1234, "pc vector");
    chk({16'h0, program_counter}, 32'h1234, "pc port");
    rdchk(`CRS_OFF_FLAGS, 32'h68, "flags reset");
    apb(1'b0, `CRS_OFF_IDX, 32'h0);
    chk({24'h0, rv[15:8]}, 32'h0, "upper index reset");
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, ev}, 32'h1, "unmapped error");
    chk(rv, 32'h0, "unmapped data");
  endtask

  task automatic t_arith;
    cmd(OP_LDA, 16'h007f);
    cmd(OP_ADD, 16'h0001);
    rdchk(`CRS_OFF_ACC, 32'h80, "add sum");
    rdchk(`CRS_OFF_FLAGS, 32'hfc, "overflow flags");
    cmd(OP_ADD, 16'h0080);
    rdchk(`CRS_OFF_FLAGS, 32'heb, "carry flags");
    cmd(OP_SUB, 16'h0001);
    apb(1'b0, `CRS_OFF_FLAGS, 32'h0);
    chk(rv & 32'hef, 32'h6d, "borrow flags");
    cmd(OP_LDA, 16'h0009);
    cmd(OP_ADD, 16'h0008);
    apb(1'b0, `CRS_OFF_FLAGS, 32'h0);
    chk(rv & 32'h10, 32'h10, "half carry");
    cmd(OP_DAA, 16'h0000);
    rdchk(`CRS_OFF_ACC, 32'h17, "decimal adjust");
  endtask

  task automatic t_index;
    crs_op_t    ops [7];
    logic [7:0] exp [7];
    ops = '{OP_COMX, OP_NEGX, OP_INCX, OP_CLRX, OP_DECX, OP_LSRX, OP_ROLX};
    exp = '{8'hff, 8'h01, 8'h02, 8'h00, 8'hff, 8'h7f, 8'hff};
    cmd(OP_LDHX, 16'h12fe);
    cmd(OP_IXINC, 16'h0000);
    cmd(OP_IXINC, 16'h0000);
    rdchk(`CRS_OFF_IDX, 32'h1300, "index carry");
    chk({16'h0, ix_pointer}, 32'h1300, "index port");
    foreach (ops[i]) begin
      cmd(ops[i], 16'h0000);
      rdchk(`CRS_OFF_IDX, {16'h0, 8'h13, exp[i]}, "lower byte op");
    end
  endtask

  task automatic t_stack;
    cmd(OP_AIS, 16'h0080);
    rdchk(`CRS_OFF_SP, 32'h007f, "negative add");
    cmd(OP_AIS, 16'h007f);
    cmd(OP_AIS, 16'h007f);
    rdchk(`CRS_OFF_SP, 32'h017d, "positive add");
    cmd(OP_RSP, 16'h0000);
    rdchk(`CRS_OFF_SP, 32'h01ff, "stack reset low");
    chk({16'h0, stack_pointer}, 32'h01ff, "sp port");
  endtask

  task automatic t_pc;
    cmd(OP_JMP, 16'h4000);
    cmd(OP_FETCH, 16'h0000);
    rdchk(`CRS_OFF_PC, 32'h4001, "fetch step");
    cmd(OP_BRA, 16'h00fe);
    rdchk(`CRS_OFF_PC, 32'h3fff, "branch back");
  endtask

  task automatic t_irq;
    cmd(OP_SEI, 16'h0000);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, irq_accept}, 32'h0, "masked request");
    cmd(OP_CLI, 16'h0000);
    repeat (6) @(posedge clk);
    chk({31'h0, irq_accept}, 32'h0, "shadow after clear");
    cmd(OP_NOP, 16'h0000);
    repeat (5) @(posedge clk);
    chk({31'h0, irq_accept}, 32'h1, "accepted");
    cmd(OP_INTR, 16'h5000);
    irq_req <= 1'b0;
    apb(1'b0, `CRS_OFF_FLAGS, 32'h0);
    chk(rv & 32'h08, 32'h08, "entry mask");
    rdchk(`CRS_OFF_SP, 32'h01fa, "stacked frame");
    rdchk(`CRS_OFF_PC, 32'h5000, "service entry");
  endtask

  task automatic t_flags;
    cmd(OP_LDA, 16'h0000);
    apb(1'b0, `CRS_OFF_FLAGS, 32'h0);
    chk(rv & 32'h06, 32'h02, "zero load");
    cmd(OP_TAP, 16'h0000);
    rdchk(`CRS_OFF_FLAGS, 32'h60, "fixed ones kept");
  endtask

  // Second reset mid-run: only some registers may move
  task automatic t_rerst;
    cmd(OP_LDA, 16'h005a);
    cmd(OP_LDHX, 16'habcd);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, mem_rd}, 32'h1, "vector read in reset");
    chk({16'h0, mem_addr}, {16'h0, `CRS_VEC_HI_ADR}, "vector high address");
    chk({16'h0, stack_pointer}, 32'h00ff, "sp port in reset");
    resetn <= 1'b1;
    // Command lands while the vector fetch is still running
    apb(1'b1, `CRS_OFF_CMD, {27'h0, OP_CLRX});
    chk({31'h0, ev}, 32'h1, "command before run");
    wait_run();
    rdchk(`CRS_OFF_PC, 32'h1234, "pc vector again");
    rdchk(`CRS_OFF_ACC, 32'h5a, "acc kept");
    rdchk(`CRS_OFF_IDX, 32'h00cd, "lower kept");
    rdchk(`CRS_OFF_SP, 32'h00ff, "sp reloaded");
  endtask

  // ********************************
  // Run control
  // ********************************
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial begin
    resetn    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    irq_req   = 1'b0;
    failures  = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_arith();
    t_index();
    t_stack();
    t_pc();
    t_irq();
    t_flags();
    t_rerst();
    end_of_test();
  end
endmodule
